// [design/sclk_pkg.sv]
package sclk_pkg;

    // ==========================================================
    // Register map (word addresses on the plain port)
    localparam logic [3:0] ADDR_MCU_CTRL = 4'h0;
    localparam logic [3:0] ADDR_OSC_TRIM = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_STARTUP = 4'h3;

    // ==========================================================
    // Control field layout
    localparam int SLEEP_ALLOW_BIT = 5;
    localparam int SLEEP_SEL_LSB = 2;
    localparam int SLEEP_SEL_W = 3;
    localparam logic [7:0] MCU_CTRL_RESET = 8'h00;

    // ==========================================================
    // Sleep select encodings
    localparam logic [2:0] SEL_IDLE = 3'h0;
    localparam logic [2:0] SEL_ADC_NR = 3'h1;
    localparam logic [2:0] SEL_PDOWN = 3'h2;
    localparam logic [2:0] SEL_PSAVE = 3'h3;
    localparam logic [2:0] SEL_STBY = 3'h6;
    localparam logic [2:0] SEL_XSTBY = 3'h7;

    // ==========================================================
    // Timing
    localparam int HALT_CYCLES = 4;
    localparam int STBY_WAKE_CK = 6;
    localparam logic [15:0] STARTUP_RESET = 16'h0006;
    localparam int CNT_W = 16;

    // ==========================================================
    // Wake source bit positions
    localparam int WK_EXT_LOW = 0;
    localparam int WK_EXT_HIGH_LVL = 1;
    localparam int WK_TWI_MATCH = 2;
    localparam int WK_TIMER0 = 3;
    localparam int WK_NVM_READY = 4;
    localparam int WK_ADC_DONE = 5;
    localparam int WK_OTHER_IO = 6;
    localparam int WK_W = 7;

    typedef enum logic [2:0] {
        SCLK_RUN = 3'b000,
        SCLK_SLEEP = 3'b001,
        SCLK_RESTART = 3'b011,
        SCLK_HALT = 3'b010
    } sclk_state_t;

endpackage : sclk_pkg

// [design/sclk_sync.sv]
`timescale 1ns/1ps
// ==========================================================
// Three-stage sampler; change accepted when stages two and three agree
module sclk_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            dout <= 1'b0;
        else if (s2 == s3)
            dout <= s3;
    end
endmodule : sclk_sync

// [design/sclk_wake_qual.sv]
`timescale 1ns/1ps
// ==========================================================
// Per-mode wake source qualifier, combinational
module sclk_wake_qual (
    input wire logic [2:0] mode,
    input wire logic [sclk_pkg::WK_W-1:0] src,
    input wire logic async_sel,
    input wire logic timer0_ie,
    input wire logic global_ie,
    output logic wake
);
    logic [sclk_pkg::WK_W-1:0] allow;
    logic t0_ok;

    always_comb
    begin
        t0_ok = async_sel && timer0_ie && global_ie;
        allow = '0;
        case (mode)
            sclk_pkg::SEL_IDLE:
                allow = '1;
            sclk_pkg::SEL_ADC_NR:
            begin
                allow = '1;
                allow[sclk_pkg::WK_OTHER_IO] = 1'b0;
            end
            sclk_pkg::SEL_PDOWN, sclk_pkg::SEL_STBY:
            begin
                allow[sclk_pkg::WK_EXT_LOW] = 1'b1;
                allow[sclk_pkg::WK_EXT_HIGH_LVL] = 1'b1;
                allow[sclk_pkg::WK_TWI_MATCH] = 1'b1;
            end
            sclk_pkg::SEL_PSAVE, sclk_pkg::SEL_XSTBY:
            begin
                allow[sclk_pkg::WK_EXT_LOW] = 1'b1;
                allow[sclk_pkg::WK_EXT_HIGH_LVL] = 1'b1;
                allow[sclk_pkg::WK_TWI_MATCH] = 1'b1;
                allow[sclk_pkg::WK_TIMER0] = t0_ok;
            end
            default:
                allow = '0;
        endcase
        wake = |(allow & src);
    end
endmodule : sclk_wake_qual

// [design/sclk_ctrl.sv]
`timescale 1ns/1ps
// Behaviour
// - Reset loads factory 1 MHz trim byte
// - Trim zero slowest, all ones fastest
// - Trim register absent in legacy mode
// - Sleep needs allow bit plus instruction
// - Four halt cycles after start-up time
// - Storage kept; reset during sleep wakes
// - Select 000 Idle stops CPU, flash
// - Idle wakes on any enabled interrupt
// - Idle or ADC mode starts conversion
// - Select 001 also stops I/O clock
// - ADC mode limited wake source set
// - Select 010 stops oscillator, all clocks
// - Power-down wakes on external, address match
// - Power-down wake waits restart delay
// - Select 011 keeps async timer running
// - Timer wake needs both enables set
// - Standby modes keep oscillator, crystal only
// - Async domain only with select bit
// - Select 110 Standby, six-cycle wake
// - Select 111 extended; 100, 101 reserved
// - Allow bit 5, select bits 4:2
module sclk_ctrl (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sleep_instr,
    input wire logic [7:0] factory_trim,
    input wire logic legacy_mode,
    input wire logic crystal_selected,
    input wire logic [15:0] restart_delay,
    input wire logic timer0_async_select,
    input wire logic timer0_ie,
    input wire logic global_ie,
    input wire logic adc_enabled,
    input wire logic sys_reset_req,
    input wire logic [sclk_pkg::WK_W-1:0] wake_src,
    input wire logic ext_irq_high_level,
    output logic [7:0] oscillator_trim,
    output logic cpu_clock_domain,
    output logic flash_clock_domain,
    output logic io_clock_domain,
    output logic adc_clock_domain,
    output logic async_clock_domain,
    output logic main_osc_en,
    output logic timer_osc_en,
    output logic core_hold,
    output logic adc_auto_start,
    output logic reset_wake
);
    sclk_pkg::sclk_state_t state;
    logic [7:0] mcu_control_reg;
    logic [2:0] active_mode;
    logic [sclk_pkg::CNT_W-1:0] cnt;
    logic trim_loaded;
    logic high_lvl_sync;
    logic wake_hit;
    logic [sclk_pkg::WK_W-1:0] src_all;
    logic sleep_allow;
    logic [2:0] sleep_select;
    logic sleep_go;
    logic mode_legal;
    logic [sclk_pkg::CNT_W-1:0] next_restart;
    logic [sclk_pkg::CNT_W-1:0] restart_reg;

    assign sleep_allow = mcu_control_reg[sclk_pkg::SLEEP_ALLOW_BIT];
    assign sleep_select = mcu_control_reg[sclk_pkg::SLEEP_SEL_LSB +: sclk_pkg::SLEEP_SEL_W];

    // ==========================================================
    // Mode legality: reserved codes and standby without crystal never sleep
    always_comb
    begin
        case (sleep_select)
            sclk_pkg::SEL_IDLE, sclk_pkg::SEL_ADC_NR,
            sclk_pkg::SEL_PDOWN, sclk_pkg::SEL_PSAVE:
                mode_legal = 1'b1;
            sclk_pkg::SEL_STBY, sclk_pkg::SEL_XSTBY:
                mode_legal = crystal_selected;
            default:
                mode_legal = 1'b0;
        endcase
    end

    assign sleep_go = sleep_instr && sleep_allow && mode_legal;

    // ==========================================================
    // Wake sources
    sclk_sync u_lvl_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .din(ext_irq_high_level),
        .dout(high_lvl_sync)
    );

    always_comb
    begin
        src_all = wake_src;
        // Only a held level wakes from the deep modes
        src_all[sclk_pkg::WK_EXT_HIGH_LVL] = high_lvl_sync;
    end

    sclk_wake_qual u_qual (
        .mode(active_mode),
        .src(src_all),
        .async_sel(timer0_async_select),
        .timer0_ie(timer0_ie),
        .global_ie(global_ie),
        .wake(wake_hit)
    );

    // ==========================================================
    // Register file
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            mcu_control_reg <= sclk_pkg::MCU_CTRL_RESET;
        else if (reg_wr && reg_addr == sclk_pkg::ADDR_MCU_CTRL)
            mcu_control_reg <= reg_wdata;
    end

    // Strap caught by clock after release, not by the async reset
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oscillator_trim <= 8'h00;
            trim_loaded <= 1'b0;
        end
        else if (!trim_loaded)
        begin
            oscillator_trim <= factory_trim;
            trim_loaded <= 1'b1;
        end
        else if (reg_wr && reg_addr == sclk_pkg::ADDR_OSC_TRIM && !legacy_mode)
            oscillator_trim <= reg_wdata;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            restart_reg <= sclk_pkg::STARTUP_RESET;
        else
            restart_reg <= next_restart;
    end

    // Restart delay follows the clock-source settings; standby uses fixed wake
    always_comb
    begin
        next_restart = restart_delay;
        if (restart_delay == '0)
            next_restart = sclk_pkg::STARTUP_RESET;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            if (reg_addr == sclk_pkg::ADDR_MCU_CTRL)
                reg_rdata <= mcu_control_reg;
            else if (reg_addr == sclk_pkg::ADDR_OSC_TRIM)
                reg_rdata <= legacy_mode ? 8'h00 : oscillator_trim;
            else if (reg_addr == sclk_pkg::ADDR_STATUS)
                reg_rdata <= {3'h0, core_hold, active_mode, state != sclk_pkg::SCLK_RUN};
            else if (reg_addr == sclk_pkg::ADDR_STARTUP)
                reg_rdata <= restart_reg[7:0];
            else
                reg_rdata <= 8'h00;
        end
        else
            reg_rdata <= 8'h00;
    end

    // ==========================================================
    // Sleep sequencer
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= sclk_pkg::SCLK_RUN;
            active_mode <= sclk_pkg::SEL_IDLE;
            cnt <= '0;
        end
        else if (sys_reset_req)
        begin
            // Reset aborts sleep; core restarts from its reset vector
            state <= sclk_pkg::SCLK_RUN;
            cnt <= '0;
        end
        else
        begin
            case (state)
                sclk_pkg::SCLK_RUN:
                    if (sleep_go)
                    begin
                        state <= sclk_pkg::SCLK_SLEEP;
                        active_mode <= sleep_select;
                    end
                sclk_pkg::SCLK_SLEEP:
                    if (wake_hit)
                    begin
                        state <= sclk_pkg::SCLK_RESTART;
                        if (active_mode == sclk_pkg::SEL_IDLE
                            || active_mode == sclk_pkg::SEL_ADC_NR)
                            cnt <= '0;
                        else if (active_mode == sclk_pkg::SEL_STBY
                            || active_mode == sclk_pkg::SEL_XSTBY)
                            cnt <= sclk_pkg::CNT_W'(sclk_pkg::STBY_WAKE_CK - 1);
                        else
                            cnt <= restart_reg - 16'h0001;
                    end
                sclk_pkg::SCLK_RESTART:
                    if (cnt == '0)
                    begin
                        state <= sclk_pkg::SCLK_HALT;
                        cnt <= sclk_pkg::CNT_W'(sclk_pkg::HALT_CYCLES - 1);
                    end
                    else
                        cnt <= cnt - 16'h0001;
                sclk_pkg::SCLK_HALT:
                    if (cnt == '0)
                        state <= sclk_pkg::SCLK_RUN;
                    else
                        cnt <= cnt - 16'h0001;
                default:
                    state <= sclk_pkg::SCLK_RUN;
            endcase
        end
    end

    // ==========================================================
    // Clock gates; storage domains are only clock-gated, never cleared
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cpu_clock_domain <= 1'b1;
            flash_clock_domain <= 1'b1;
            io_clock_domain <= 1'b1;
            adc_clock_domain <= 1'b1;
            main_osc_en <= 1'b1;
        end
        else if (state == sclk_pkg::SCLK_SLEEP && !sys_reset_req)
        begin
            cpu_clock_domain <= 1'b0;
            flash_clock_domain <= 1'b0;
            io_clock_domain <= active_mode == sclk_pkg::SEL_IDLE;
            adc_clock_domain <= active_mode == sclk_pkg::SEL_IDLE
                || active_mode == sclk_pkg::SEL_ADC_NR;
            main_osc_en <= active_mode == sclk_pkg::SEL_IDLE
                || active_mode == sclk_pkg::SEL_ADC_NR
                || active_mode == sclk_pkg::SEL_STBY
                || active_mode == sclk_pkg::SEL_XSTBY;
        end
        else
        begin
            cpu_clock_domain <= 1'b1;
            flash_clock_domain <= 1'b1;
            io_clock_domain <= 1'b1;
            adc_clock_domain <= 1'b1;
            main_osc_en <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            async_clock_domain <= 1'b0;
            timer_osc_en <= 1'b0;
        end
        else if (state == sclk_pkg::SCLK_SLEEP
            && (active_mode == sclk_pkg::SEL_PDOWN || active_mode == sclk_pkg::SEL_STBY))
        begin
            async_clock_domain <= 1'b0;
            timer_osc_en <= 1'b0;
        end
        else
        begin
            async_clock_domain <= timer0_async_select;
            timer_osc_en <= timer0_async_select;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            core_hold <= 1'b0;
        else
            core_hold <= (state != sclk_pkg::SCLK_RUN || sleep_go) && !sys_reset_req;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adc_auto_start <= 1'b0;
            reset_wake <= 1'b0;
        end
        else
        begin
            adc_auto_start <= sleep_go && adc_enabled
                && (sleep_select == sclk_pkg::SEL_IDLE
                || sleep_select == sclk_pkg::SEL_ADC_NR);
            reset_wake <= sys_reset_req && state != sclk_pkg::SCLK_RUN;
        end
    end

    // ==========================================================
    // Checks
    a_sleep_needs_allow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sclk_pkg::SCLK_RUN && sleep_instr && !sleep_allow && !sys_reset_req)
        |=> state == sclk_pkg::SCLK_RUN)
        else $error("sleep entered without allow bit");
    a_halt_four: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($rose(state == sclk_pkg::SCLK_HALT) && !sys_reset_req) |->
        (state == sclk_pkg::SCLK_HALT && !sys_reset_req)[*4] ##1 1'b1)
        else $error("halt stage not four cycles");
    a_idle_clocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sclk_pkg::SCLK_SLEEP && active_mode == sclk_pkg::SEL_IDLE
        && !sys_reset_req) |=> !cpu_clock_domain && io_clock_domain)
        else $error("idle gating wrong");
    a_adc_nr_clocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sclk_pkg::SCLK_SLEEP && active_mode == sclk_pkg::SEL_ADC_NR
        && !sys_reset_req) |=> !io_clock_domain && adc_clock_domain)
        else $error("adc mode gating wrong");
    a_pdown_osc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sclk_pkg::SCLK_SLEEP && active_mode == sclk_pkg::SEL_PDOWN
        && !sys_reset_req) |=> !main_osc_en && !async_clock_domain)
        else $error("power-down left a clock");
    a_reserved_no_sleep: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sclk_pkg::SCLK_RUN && sleep_select[2:1] == 2'b10 && !sys_reset_req)
        |=> state == sclk_pkg::SCLK_RUN)
        else $error("reserved mode entered");
    a_trim_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(trim_loaded) |-> oscillator_trim == $past(factory_trim))
        else $error("trim not loaded");
    a_legacy_trim: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (legacy_mode && trim_loaded && $past(trim_loaded)) |-> $stable(oscillator_trim))
        else $error("trim written in legacy mode");
    a_stby_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == sclk_pkg::SCLK_SLEEP && active_mode == sclk_pkg::SEL_STBY && wake_hit
        && !sys_reset_req) |=> (state == sclk_pkg::SCLK_RESTART)[*6])
        else $error("standby wake not six cycles");
    a_async_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !$past(timer0_async_select) |-> !async_clock_domain)
        else $error("async clock without select");
    c_idle_sleep: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state == sclk_pkg::SCLK_SLEEP && active_mode == sclk_pkg::SEL_IDLE);
    c_pdown_wake: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state == sclk_pkg::SCLK_SLEEP && active_mode == sclk_pkg::SEL_PDOWN ##1
        state == sclk_pkg::SCLK_RESTART);
    c_reset_wake: cover property (@(posedge sys_clk) disable iff (!rst_n) reset_wake);
endmodule : sclk_ctrl

// [verification/sclk_core_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Core and interrupt sources facing the sleep controller
module sclk_core_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic go_sleep,
    input wire logic [sclk_pkg::WK_W-1:0] irq_req,
    input wire logic core_hold,
    output logic sleep_instr,
    output logic [sclk_pkg::WK_W-1:0] wake_src,
    output logic ext_irq_high_level
);
    // ==========================================================
    // Sleep instruction, one cycle per request
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sleep_instr <= 1'b0;
        else
            sleep_instr <= go_sleep;
    end

    // ==========================================================
    // Sources held while stalled, so the slow level sampler sees them
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_src <= '0;
            ext_irq_high_level <= 1'b0;
        end
        else
        begin
            wake_src <= irq_req & {sclk_pkg::WK_W{core_hold}} & 7'h7d;
            ext_irq_high_level <= irq_req[sclk_pkg::WK_EXT_HIGH_LVL] & core_hold;
        end
    end
endmodule : sclk_core_model

// [verification/test_sleep_clock_gating_control.sv]
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench
module test_sleep_clock_gating_control;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] factory_trim = 8'h00;
    logic legacy_mode = 1'b0;
    logic crystal_selected = 1'b1;
    logic [15:0] restart_delay = 16'h0000;
    logic timer0_async_select = 1'b0;
    logic timer0_ie = 1'b1;
    logic global_ie = 1'b1;
    logic adc_enabled = 1'b0;
    logic sys_reset_req = 1'b0;
    logic go_sleep = 1'b0;
    logic [6:0] irq_req = 7'h00;
    logic [7:0] reg_rdata, oscillator_trim, d, v;
    logic sleep_instr, ext_irq_high_level, core_hold, adc_auto_start, reset_wake;
    logic cpu_c, flash_c, io_c, adc_c, async_c, main_osc_en, timer_osc_en;
    logic [6:0] wake_src;
    logic [7:0] tbl [13] = '{8'h1b, 8'h39, 8'h37, 8'h51, 8'h43, 8'h47,
                             8'h6f, 8'h6c, 8'hcb, 8'hef, 8'h59, 8'h4d, 8'h6d};
    int seed = 59;
    int n_fail = 0;
    int compares = 0;
    int n_adc = 0;
    int n_rw = 0;

    always #2.5 sys_clk = ~sys_clk;

    sclk_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_instr(sleep_instr), .factory_trim(factory_trim), .legacy_mode(legacy_mode),
        .crystal_selected(crystal_selected), .restart_delay(restart_delay),
        .timer0_async_select(timer0_async_select), .timer0_ie(timer0_ie),
        .global_ie(global_ie), .adc_enabled(adc_enabled), .sys_reset_req(sys_reset_req),
        .wake_src(wake_src), .ext_irq_high_level(ext_irq_high_level),
        .oscillator_trim(oscillator_trim), .cpu_clock_domain(cpu_c),
        .flash_clock_domain(flash_c), .io_clock_domain(io_c), .adc_clock_domain(adc_c),
        .async_clock_domain(async_c), .main_osc_en(main_osc_en),
        .timer_osc_en(timer_osc_en), .core_hold(core_hold),
        .adc_auto_start(adc_auto_start), .reset_wake(reset_wake));

    sclk_core_model partner (.sys_clk(sys_clk), .rst_n(rst_n), .go_sleep(go_sleep),
        .irq_req(irq_req), .core_hold(core_hold), .sleep_instr(sleep_instr),
        .wake_src(wake_src), .ext_irq_high_level(ext_irq_high_level));

    // ==========================================================
    // Pulse counters
    always @(posedge sys_clk)
    begin
        if (adc_auto_start === 1'b1)
            n_adc++;
        if (reset_wake === 1'b1)
            n_rw++;
    end

    task close_out;
        $display("counts compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [7:0] x);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, output logic [7:0] x);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        x = reg_rdata;
    endtask : rd

    // Order {cpu, flash, io, adc, async, timer osc, main osc}
    function logic [6:0] exp_clk(input logic [2:0] s, input logic a);
        case (s)
            sclk_pkg::SEL_IDLE: return {4'b0011, a, a, 1'b1};
            sclk_pkg::SEL_ADC_NR: return {4'b0001, a, a, 1'b1};
            sclk_pkg::SEL_PSAVE: return {4'b0000, a, a, 1'b0};
            sclk_pkg::SEL_STBY: return 7'h01;
            sclk_pkg::SEL_XSTBY: return {4'b0000, a, a, 1'b1};
            default: return 7'h00;
        endcase
    endfunction : exp_clk

    function int wake_n(input logic [2:0] s);
        if (s < 3'h2)
            return 1;
        if (s >= 3'h6 || restart_delay == 16'h0000)
            return sclk_pkg::STBY_WAKE_CK;
        return int'(restart_delay);
    endfunction : wake_n

    task sleep_case(input logic [2:0] s, input logic al, input int b, input logic ent,
        input logic wk);
        int c;
        int a0;
        int r;
        a0 = n_adc;
        wr(sclk_pkg::ADDR_MCU_CTRL, {2'h0, al, s, 2'h0});
        @(posedge sys_clk);
        go_sleep <= 1'b1;
        @(posedge sys_clk);
        go_sleep <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        chk(16'(core_hold), 16'(ent));
        chk({cpu_c, flash_c, io_c, adc_c, async_c, timer_osc_en, main_osc_en},
            ent ? exp_clk(s, timer0_async_select)
                : {4'hf, timer0_async_select, timer0_async_select, 1'b1});
        chk(16'(n_adc - a0), 16'(ent && adc_enabled && s < 3'h2));
        if (!ent)
            return;
        c = 0;
        @(posedge sys_clk);
        irq_req[b] <= 1'b1;
        while (core_hold === 1'b1 && c < 60)
        begin
            @(posedge sys_clk);
            #1;
            c++;
        end
        if (wk)
            chk(16'(c >= wake_n(s) + 4 && c <= wake_n(s) + 16), 16'h1);
        else
        begin
            chk(16'(c), 16'd60);
            r = n_rw;
            @(posedge sys_clk);
            sys_reset_req <= 1'b1;
            @(posedge sys_clk);
            sys_reset_req <= 1'b0;
            repeat (3) @(posedge sys_clk);
            #1;
            chk(16'(n_rw - r), 16'h1);
            chk(16'(core_hold), 16'h0);
        end
        @(posedge sys_clk);
        irq_req <= 7'h00;
        repeat (2) @(posedge sys_clk);
    endtask : sleep_case

    // ==========================================================
    // Watchdog, far beyond the expected run length
    initial
    begin
        #200000;
        n_fail++;
        close_out();
    end

    initial
    begin
        factory_trim = 8'($random(seed));
        restart_delay = 16'(8 + ($random(seed) & 7));
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(sclk_pkg::ADDR_OSC_TRIM, d);
        chk(16'(d), 16'(factory_trim));
        chk(16'(oscillator_trim), 16'(factory_trim));
        rd(sclk_pkg::ADDR_MCU_CTRL, d);
        chk(16'(d), 16'(sclk_pkg::MCU_CTRL_RESET));
        rd(sclk_pkg::ADDR_STARTUP, d);
        chk(16'(d), 16'(restart_delay[7:0]));
        v = 8'($random(seed));
        // No nonvolatile writes run here, so any trim value is safe
        wr(sclk_pkg::ADDR_OSC_TRIM, v);
        rd(sclk_pkg::ADDR_OSC_TRIM, d);
        chk(16'(d), 16'(v));
        chk(16'(oscillator_trim), 16'(v));
        legacy_mode <= 1'b1;
        wr(sclk_pkg::ADDR_OSC_TRIM, ~v);
        rd(sclk_pkg::ADDR_OSC_TRIM, d);
        chk(16'(d), 16'h0);
        legacy_mode <= 1'b0;
        rd(sclk_pkg::ADDR_OSC_TRIM, d);
        chk(16'(d), 16'(v));
        rd(4'hf, d);
        chk(16'(d), 16'h0);
        wr(sclk_pkg::ADDR_MCU_CTRL, 8'h3c);
        rd(sclk_pkg::ADDR_MCU_CTRL, d);
        chk(16'(d & 8'h3c), 16'h3c);
        $display("test registers done");
        sleep_case(3'h0, 1'b0, 6, 1'b0, 1'b0);
        sleep_case(3'h4, 1'b1, 6, 1'b0, 1'b0);
        sleep_case(3'h5, 1'b1, 6, 1'b0, 1'b0);
        crystal_selected <= 1'b0;
        sleep_case(3'h6, 1'b1, 2, 1'b0, 1'b0);
        crystal_selected <= 1'b1;
        $display("test refused entry done");
        for (int i = 0; i < 13; i++)
        begin
            adc_enabled <= 1'($random(seed));
            global_ie <= tbl[i][0];
            timer0_ie <= tbl[i][1] | ~tbl[i][0];
            timer0_async_select <= (tbl[i][4:2] == 3'h3) | 1'($random(seed));
            sleep_case(tbl[i][7:5], 1'b1, int'(tbl[i][4:2]), 1'b1, tbl[i][1]);
        end
        $display("test sleep modes done");
        close_out();
    end
endmodule : test_sleep_clock_gating_control
